//--- lindf_chk.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module lindf_chk (
  input wire hclk,             // Clock
  input wire hresetn,          // Reset, active low
  input wire hsel,             // Select
  input wire [31:0] haddr,     // Address
  input wire [1:0] htrans,     // Transfer type
  input wire hwrite,           // Write
  input wire [2:0] hsize,      // Size
  input wire [31:0] hwdata,    // Write data
  input wire hready,           // Bus ready
  input wire hreadyout,        // Slave ready
  input wire hresp,            // Response
  input wire [31:0] hrdata,    // Read data
  input wire lin_rxd,          // Receive line
  input wire fast_osc_clock,   // Fast ticks
  input wire slow_osc_clock,   // Slow ticks
  input wire rx_timeout_fault, // Timeout fault
  input wire stuck_active,     // Stuck state
  input wire break_exit_req,   // Exit pulse
  input wire lin_wakeup_req,   // Wake request
  input wire stuck_wakeup_req  // Stuck wake request
);
  wire take = hsel && htrans[1] && hready;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_RD_WAIT: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait");
  AST_WR_ZERO: assert property (take && hwrite |=> hreadyout) else $error("write wait");
  AST_HRD_TOP: assert property (hrdata[31:8] == 24'h000000) else $error("upper read bits");
  AST_RESP: assert property (hresp == 1'b0) else $error("response not okay");
  AST_FLT_CLR: assert property (lin_rxd [*4] |=> !rx_timeout_fault) else $error("fault kept");
  AST_EXIT_ONE: assert property (break_exit_req |=> !break_exit_req) else $error("exit pulse long");
  AST_EXIT_CAUSE: assert property (break_exit_req |-> $past(rx_timeout_fault)) else $error("exit no fault");
  AST_STK_WAKE: assert property ($rose(stuck_wakeup_req) |-> stuck_active) else $error("stuck wake");
  cover property (break_exit_req);
  cover property ($rose(stuck_active));
  cover property ($rose(lin_wakeup_req));
  cover property ($rose(stuck_wakeup_req));
endmodule

bind lindf_monitor lindf_chk lindf_chk_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
  .hwdata, .hready, .hreadyout, .hresp, .hrdata, .lin_rxd, .fast_osc_clock, .slow_osc_clock,
  .rx_timeout_fault, .stuck_active, .break_exit_req, .lin_wakeup_req, .stuck_wakeup_req);

//--- lindf_lin_bus.sv
`timescale 1ns/1ps
// ----------------------------------------
// LIN transceiver side and oscillator ticks
// ----------------------------------------
module lindf_lin_bus (
  input wire dom,            // Bench asks for dominant
  output wire lin_rxd,       // Receive line, pull-up when recessive
  output reg fast_osc_clock, // Fast ticks, 5 MHz
  output reg slow_osc_clock  // Slow ticks, scaled to 1 MHz to keep runs short
);
  initial fast_osc_clock = 1'b0;
  initial slow_osc_clock = 1'b0;
  always #100 fast_osc_clock = ~fast_osc_clock;
  always #500 slow_osc_clock = ~slow_osc_clock;
  assign lin_rxd = dom ? 1'b0 : 1'b1;
endmodule

//--- lindf_monitor.v
`timescale 1ns/1ps
`include "lindf_regs.vh"

// Functional notes
// (R01) Low timeout byte holds value bits 8..1, read/write, resets to zero.
// (R02) High timeout byte holds value bits 16..9, read/write, resets to zero.
// (R03) Clear width low byte, read/write, resets to zero.
// (R04) Clear width high byte, read/write, resets to zero.
// (R05) Wake-up needs dominant for filter setting plus one slow clock periods.
// (R06) Wake-up request raised only while the wake-up enable bit is set.
// (R07) Wake-up flag set by hardware, stays set until software writes zero.
// (R08) Stuck wake-up enable and flag; stuck request only when enabled.
// (R09) Enable set: leave break state automatically on receive dominant fault.
// (R10) Timeout after line dominant for 17-bit value plus one fast clock cycles.
// (R11) Stuck active after active width plus one, clear after clear width plus one.
module lindf_monitor (
  input wire hclk,               // Bus clock, 20 MHz
  input wire hresetn,            // Asynchronous reset, active low
  input wire hsel,               // AHB slave select
  input wire [31:0] haddr,       // AHB address
  input wire [1:0] htrans,       // AHB transfer type
  input wire hwrite,             // AHB write
  input wire [2:0] hsize,        // AHB transfer size
  input wire [31:0] hwdata,      // AHB write data
  input wire hready,             // AHB bus ready
  output wire hreadyout,         // AHB slave ready
  output wire hresp,             // AHB response, always OKAY
  output reg [31:0] hrdata,      // AHB read data
  input wire lin_rxd,            // Receive line from transceiver, low is dominant
  input wire fast_osc_clock,     // Internal fast oscillator, sampled
  input wire slow_osc_clock,     // Slow 32 kHz clock, sampled
  output reg rx_timeout_fault,   // Receive line dominant timeout reached
  output reg stuck_active,       // Bus stuck dominant state
  output reg break_exit_req,     // One-cycle request to leave the break state
  output wire lin_wakeup_req,    // LIN wake-up request
  output wire stuck_wakeup_req   // Bus stuck wake-up request
);

  // --------------------------------------------------------------------------
  // Input synchronisation and tick generation
  // --------------------------------------------------------------------------
  wire [2:0] sync_bus;
  wire rxd_s;
  wire fast_s;
  wire slow_s;
  reg fast_d_reg;
  reg slow_d_reg;
  wire fast_tick;
  wire slow_tick;
  wire dominant;

  lindf_sync #(
    .WIDTH(3)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({slow_osc_clock, fast_osc_clock, lin_rxd}),
    .sync_out(sync_bus)
  );

  assign rxd_s = sync_bus[0];
  assign fast_s = sync_bus[1];
  assign slow_s = sync_bus[2];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fast_d_reg <= 1'b1;
      slow_d_reg <= 1'b1;
    end else begin
      fast_d_reg <= fast_s;
      slow_d_reg <= slow_s;
    end
  end

  // Sampled clocks only count correctly below half the bus clock rate
  assign fast_tick = fast_s & ~fast_d_reg;
  assign slow_tick = slow_s & ~slow_d_reg;
  assign dominant = ~rxd_s;

  // --------------------------------------------------------------------------
  // AHB-Lite slave
  // --------------------------------------------------------------------------
  reg wr_pend_reg;
  reg rd_pend_reg;
  reg [`LINDF_IDX_W-1:0] idx_reg;
  reg idx_ok_reg;
  wire accept;
  wire wr_en;
  wire [7:0] wbyte;

  assign accept = hsel & htrans[1] & hready;
  assign hreadyout = ~rd_pend_reg;
  assign hresp = 1'b0;
  assign wr_en = wr_pend_reg & idx_ok_reg;
  assign wbyte = hwdata[7:0];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      idx_reg <= {`LINDF_IDX_W{1'b0}};
      idx_ok_reg <= 1'b0;
    end else begin
      wr_pend_reg <= accept & hwrite;
      // Reads take one wait state so that a write just before is visible
      rd_pend_reg <= accept & ~hwrite;
      if (accept) begin
        idx_reg <= haddr[`LINDF_IDX_W+1:2];
        idx_ok_reg <= (haddr[31:`LINDF_IDX_W+2] == {(30-`LINDF_IDX_W){1'b0}}) && (haddr[1:0] == 2'b00);
      end
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg [7:0] rx_timeout_control_reg;
  reg [7:0] rx_dominant_timeout_low_reg;
  reg [7:0] rx_dominant_timeout_high_reg;
  reg [7:0] stuck_clear_width_low_reg;
  reg [7:0] stuck_clear_width_high_reg;
  reg [7:0] stuck_active_width_reg;
  reg lin_wakeup_enable_reg;
  reg stuck_wakeup_enable_reg;
  reg [`LINDF_FLT_W-1:0] wakeup_filter_setting_reg;
  reg lin_wakeup_flag_reg;
  reg stuck_wakeup_flag_reg;
  wire lin_wake_event;
  wire stuck_event;
  wire sel_ctrl;
  wire sel_wcfg;

  assign sel_ctrl = wr_en && (idx_reg == `LINDF_IDX_TO_CTRL);
  assign sel_wcfg = wr_en && (idx_reg == `LINDF_IDX_WAKE_CFG);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_timeout_control_reg <= `LINDF_RESET_BYTE;
      rx_dominant_timeout_low_reg <= `LINDF_RESET_BYTE;
      rx_dominant_timeout_high_reg <= `LINDF_RESET_BYTE;
      stuck_clear_width_low_reg <= `LINDF_RESET_BYTE;
      stuck_clear_width_high_reg <= `LINDF_RESET_BYTE;
      stuck_active_width_reg <= `LINDF_RESET_BYTE;
      lin_wakeup_enable_reg <= 1'b0;
      stuck_wakeup_enable_reg <= 1'b0;
      wakeup_filter_setting_reg <= {`LINDF_FLT_W{1'b0}};
    end else if (wr_en) begin
      case (idx_reg)
        `LINDF_IDX_TO_CTRL: begin
          rx_timeout_control_reg <= {wbyte[7:6], 6'h00};
        end
        `LINDF_IDX_RXTO_LOW: begin
          rx_dominant_timeout_low_reg <= wbyte; // R01
        end
        `LINDF_IDX_RXTO_HIGH: begin
          rx_dominant_timeout_high_reg <= wbyte; // R02
        end
        `LINDF_IDX_CLR_LOW: begin
          stuck_clear_width_low_reg <= wbyte; // R03
        end
        `LINDF_IDX_CLR_HIGH: begin
          stuck_clear_width_high_reg <= wbyte; // R04
        end
        `LINDF_IDX_ACT_WIDTH: begin
          stuck_active_width_reg <= wbyte;
        end
        `LINDF_IDX_WAKE_CFG: begin
          stuck_wakeup_enable_reg <= wbyte[`LINDF_WCFG_SWEN_BIT]; // R08
          lin_wakeup_enable_reg <= wbyte[`LINDF_WCFG_LWEN_BIT]; // R06
          wakeup_filter_setting_reg <= wbyte[`LINDF_WCFG_FLT_MSB:`LINDF_WCFG_FLT_LSB];
        end
        default: begin
        end
      endcase
    end
  end

  // Flags: a hardware event in the same cycle as a clearing write wins
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lin_wakeup_flag_reg <= 1'b0;
      stuck_wakeup_flag_reg <= 1'b0;
    end else begin
      if (lin_wake_event && lin_wakeup_enable_reg) begin
        lin_wakeup_flag_reg <= 1'b1; // R07
      end else if (sel_wcfg && !wbyte[`LINDF_WCFG_LWF_BIT]) begin
        lin_wakeup_flag_reg <= 1'b0; // R07
      end
      if (stuck_event && stuck_wakeup_enable_reg) begin
        stuck_wakeup_flag_reg <= 1'b1; // R08
      end else if (sel_wcfg && !wbyte[`LINDF_WCFG_SWF_BIT]) begin
        stuck_wakeup_flag_reg <= 1'b0;
      end
    end
  end

  assign lin_wakeup_req = lin_wakeup_flag_reg & lin_wakeup_enable_reg; // R06
  assign stuck_wakeup_req = stuck_wakeup_flag_reg & stuck_wakeup_enable_reg; // R08

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  reg [7:0] rd_byte;

  always @* begin
    rd_byte = 8'h00;
    if (idx_ok_reg) begin
      case (idx_reg)
        `LINDF_IDX_TO_CTRL: rd_byte = rx_timeout_control_reg;
        `LINDF_IDX_RXTO_LOW: rd_byte = rx_dominant_timeout_low_reg;
        `LINDF_IDX_RXTO_HIGH: rd_byte = rx_dominant_timeout_high_reg;
        `LINDF_IDX_CLR_LOW: rd_byte = stuck_clear_width_low_reg;
        `LINDF_IDX_CLR_HIGH: rd_byte = stuck_clear_width_high_reg;
        `LINDF_IDX_ACT_WIDTH: rd_byte = stuck_active_width_reg;
        `LINDF_IDX_WAKE_CFG: rd_byte = {stuck_wakeup_flag_reg, lin_wakeup_flag_reg, stuck_wakeup_enable_reg,
                                        lin_wakeup_enable_reg, wakeup_filter_setting_reg};
        `LINDF_IDX_STATUS: rd_byte = {5'h00, rxd_s, stuck_active, rx_timeout_fault};
        default: rd_byte = 8'h00;
      endcase
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_pend_reg) begin
      hrdata <= {24'h000000, rd_byte};
    end
  end

  // --------------------------------------------------------------------------
  // Receive line dominant timeout
  // --------------------------------------------------------------------------
  wire [`LINDF_RXTO_W-1:0] rx_dominant_timeout_value;
  reg [`LINDF_RXTO_W-1:0] rx_cnt_reg;
  reg rx_fault_d_reg;

  assign rx_dominant_timeout_value = {rx_dominant_timeout_high_reg, rx_dominant_timeout_low_reg,
                                      rx_timeout_control_reg[`LINDF_CTRL_RXTO0_BIT]};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_cnt_reg <= {`LINDF_RXTO_W{1'b0}};
      rx_timeout_fault <= 1'b0;
    end else if (!dominant) begin
      rx_cnt_reg <= {`LINDF_RXTO_W{1'b0}};
      rx_timeout_fault <= 1'b0;
    end else if (fast_tick && !rx_timeout_fault) begin
      // Fault on the tick that completes value plus one periods
      if (rx_cnt_reg == rx_dominant_timeout_value) begin
        rx_timeout_fault <= 1'b1; // R10
      end else begin
        rx_cnt_reg <= rx_cnt_reg + 1'b1; // R10
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_fault_d_reg <= 1'b0;
      break_exit_req <= 1'b0;
    end else begin
      rx_fault_d_reg <= rx_timeout_fault;
      break_exit_req <= rx_timeout_fault & ~rx_fault_d_reg & rx_timeout_control_reg[`LINDF_CTRL_AUTOX_BIT]; // R09
    end
  end

  // --------------------------------------------------------------------------
  // Bus stuck dominant detection
  // --------------------------------------------------------------------------
  localparam ST_FREE = 2'b01;
  localparam ST_STUCK = 2'b10;

  wire [`LINDF_CLR_W-1:0] stuck_clear_width;
  reg [1:0] st_reg;
  reg [1:0] st_next;
  reg [`LINDF_CLR_W-1:0] st_cnt_reg;
  reg [`LINDF_CLR_W-1:0] st_cnt_next;
  reg stuck_event_reg;

  assign stuck_clear_width = {stuck_clear_width_high_reg, stuck_clear_width_low_reg};
  assign stuck_event = stuck_event_reg;

  always @* begin
    st_next = st_reg;
    st_cnt_next = st_cnt_reg;
    case (st_reg)
      ST_FREE: begin
        if (!dominant) begin
          st_cnt_next = {`LINDF_CLR_W{1'b0}};
        end else if (slow_tick) begin
          if (st_cnt_reg[`LINDF_ACT_W-1:0] == stuck_active_width_reg) begin
            st_next = ST_STUCK; // R11
            st_cnt_next = {`LINDF_CLR_W{1'b0}};
          end else begin
            st_cnt_next = st_cnt_reg + 1'b1; // R11
          end
        end
      end
      ST_STUCK: begin
        if (dominant) begin
          st_cnt_next = {`LINDF_CLR_W{1'b0}};
        end else if (slow_tick) begin
          if (st_cnt_reg == stuck_clear_width) begin
            st_next = ST_FREE; // R11
            st_cnt_next = {`LINDF_CLR_W{1'b0}};
          end else begin
            st_cnt_next = st_cnt_reg + 1'b1; // R11
          end
        end
      end
      default: begin
        st_next = ST_FREE;
        st_cnt_next = {`LINDF_CLR_W{1'b0}};
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= ST_FREE;
      st_cnt_reg <= {`LINDF_CLR_W{1'b0}};
      stuck_active <= 1'b0;
      stuck_event_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      st_cnt_reg <= st_cnt_next;
      stuck_active <= (st_next == ST_STUCK);
      stuck_event_reg <= (st_reg == ST_FREE) && (st_next == ST_STUCK);
    end
  end

  // --------------------------------------------------------------------------
  // LIN wake-up filter
  // --------------------------------------------------------------------------
  reg [`LINDF_FLT_W-1:0] wk_cnt_reg;
  reg wk_done_reg;
  reg wk_event_reg;

  // One event per dominant phase; a longer pulse does not repeat it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wk_cnt_reg <= {`LINDF_FLT_W{1'b0}};
      wk_done_reg <= 1'b0;
      wk_event_reg <= 1'b0;
    end else begin
      wk_event_reg <= 1'b0;
      if (!dominant) begin
        wk_cnt_reg <= {`LINDF_FLT_W{1'b0}};
        wk_done_reg <= 1'b0;
      end else if (slow_tick && !wk_done_reg) begin
        if (wk_cnt_reg == wakeup_filter_setting_reg) begin
          wk_done_reg <= 1'b1; // R05
          wk_event_reg <= 1'b1; // R05
        end else begin
          wk_cnt_reg <= wk_cnt_reg + 1'b1; // R05
        end
      end
    end
  end

  assign lin_wake_event = wk_event_reg;

endmodule

//--- lindf_monitor_tb.sv
`timescale 1ns/1ps
module lindf_monitor_tb;
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [2:0] hsize = 3'h2;
  reg [31:0] hwdata = 32'h0;
  reg dom = 1'b0;
  wire hreadyout, hresp, lin_rxd, fast_osc_clock, slow_osc_clock;
  wire rx_timeout_fault, stuck_active, break_exit_req, lin_wakeup_req, stuck_wakeup_req;
  wire [31:0] hrdata;
  integer err_count = 0;
  integer checks_done = 0;
  integer seed = 32'hB9682F4B;
  integer pulses = 0;
  integer i;
  reg [31:0] exp_q[$];
  reg rd_pend = 1'b0;
  reg [31:0] r;
  always #25 hclk = ~hclk;
  lindf_monitor lindf_monitor_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .lin_rxd, .fast_osc_clock, .slow_osc_clock,
    .rx_timeout_fault, .stuck_active, .break_exit_req, .lin_wakeup_req, .stuck_wakeup_req);
  lindf_lin_bus lindf_lin_bus_inst (.dom, .lin_rxd, .fast_osc_clock, .slow_osc_clock);
  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task chk(input [31:0] seen, input [31:0] want);
    begin
      checks_done = checks_done + 1;
      if (seen !== want) begin
        err_count = err_count + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task wait_rdy;
    integer n;
    begin
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
        n = n + 1;
        if (n > 20) begin
          err_count = err_count + 1;
          print_verdict;
        end
        @(posedge hclk);
      end
    end
  endtask
  // Address phase is held until hready is seen, then data phase likewise
  task bus(input wr, input [15:0] idx, input [31:0] d);
    begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {14'h0, idx, 2'h0};
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy;
    end
  endtask
  task wr(input [15:0] idx, input [31:0] d);
    bus(1'b1, idx, d);
  endtask
  task rd(input [15:0] idx, input [31:0] e);
    begin
      exp_q.push_back(e);
      bus(1'b0, idx, 32'h0);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge hclk);
  endtask
  // Oldest expected read value is matched when the data phase ends
  always @(posedge hclk) begin
    if (rd_pend && hreadyout) begin
      chk(hrdata, exp_q.pop_front());
      rd_pend <= 1'b0;
    end
    if (hsel && htrans[1] && hreadyout && !hwrite) rd_pend <= 1'b1;
    if (break_exit_req) pulses <= pulses + 1;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    cyc(8);
    hresetn <= 1'b1;
    cyc(1);
    for (i = 0; i < 6; i = i + 1) rd(16'hA0B3 + i, 32'h0);
    // Idle status: line recessive, no fault, not stuck
    rd(16'hA0B9, 32'h00000004);
    wr(16'hA0BA, 32'hFF);
    rd(16'hA0BA, 32'h0);
    for (i = 0; i < 6; i = i + 1) begin
      r = $random(seed);
      wr(16'hA0B3 + i, r);
      rd(16'hA0B3 + i, i == 4 ? {26'h0, r[5:0]} : {24'h0, r[7:0]});
    end
    wr(16'hA0B7, 32'h0);
    wr(16'hA0B8, 32'h3);
    wr(16'hA0B5, 32'h4);
    wr(16'hA0B6, 32'h0);
    // Timeout 5 with auto exit, then 512 without
    wr(16'hA0B4, 32'h0);
    wr(16'hA0B3, 32'h2);
    wr(16'hA0B0, 32'hC0);
    rd(16'hA0B0, 32'hC0);
    dom <= 1'b1;
    cyc(16);
    chk(rx_timeout_fault, 0);
    cyc(24);
    chk(rx_timeout_fault, 1);
    chk(pulses, 1);
    dom <= 1'b0;
    cyc(8);
    chk(rx_timeout_fault, 0);
    wr(16'hA0B4, 32'h1);
    wr(16'hA0B3, 32'h0);
    wr(16'hA0B0, 32'h0);
    dom <= 1'b1;
    cyc(1950);
    chk(rx_timeout_fault, 0);
    cyc(250);
    chk(rx_timeout_fault, 1);
    chk(pulses, 1);
    // Long dominant phase: fault and stuck both set, synced line low
    rd(16'hA0B9, 32'h00000003);
    dom <= 1'b0;
    cyc(20);
    // Wake filter 3 with enable, then without
    wr(16'hA0B7, 32'h13);
    dom <= 1'b1;
    cyc(40);
    rd(16'hA0B7, 32'h13);
    cyc(80);
    rd(16'hA0B7, 32'h53);
    chk(lin_wakeup_req, 1);
    wr(16'hA0B7, 32'h53);
    rd(16'hA0B7, 32'h53);
    wr(16'hA0B7, 32'h13);
    cyc(1);
    chk(lin_wakeup_req, 0);
    rd(16'hA0B7, 32'h13);
    dom <= 1'b0;
    cyc(20);
    wr(16'hA0B7, 32'h3);
    dom <= 1'b1;
    cyc(120);
    rd(16'hA0B7, 32'h3);
    chk(lin_wakeup_req, 0);
    chk(stuck_wakeup_req, 0);
    dom <= 1'b0;
    cyc(140);
    // Stuck: active 3, clear 4
    wr(16'hA0B7, 32'h20);
    dom <= 1'b1;
    cyc(40);
    chk(stuck_active, 0);
    cyc(80);
    chk(stuck_active, 1);
    chk(stuck_wakeup_req, 1);
    rd(16'hA0B7, 32'hA0);
    dom <= 1'b0;
    cyc(60);
    chk(stuck_active, 1);
    cyc(80);
    chk(stuck_active, 0);
    wr(16'hA0B7, 32'h20);
    cyc(2);
    chk(stuck_wakeup_req, 0);
    cyc(4);
    print_verdict;
  end
endmodule

//--- lindf_regs.vh
`ifndef LINDF_REGS_VH
`define LINDF_REGS_VH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define LINDF_IDX_TO_CTRL      16'hA0B0
`define LINDF_IDX_RXTO_LOW     16'hA0B3
`define LINDF_IDX_RXTO_HIGH    16'hA0B4
`define LINDF_IDX_CLR_LOW      16'hA0B5
`define LINDF_IDX_CLR_HIGH     16'hA0B6
`define LINDF_IDX_WAKE_CFG     16'hA0B7
`define LINDF_IDX_ACT_WIDTH    16'hA0B8
`define LINDF_IDX_STATUS       16'hA0B9
`define LINDF_IDX_W            16

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define LINDF_CTRL_RXTO0_BIT   7
`define LINDF_CTRL_AUTOX_BIT   6
`define LINDF_WCFG_SWF_BIT     7
`define LINDF_WCFG_LWF_BIT     6
`define LINDF_WCFG_SWEN_BIT    5
`define LINDF_WCFG_LWEN_BIT    4
`define LINDF_WCFG_FLT_MSB     3
`define LINDF_WCFG_FLT_LSB     0
`define LINDF_STAT_RXTO_BIT    0
`define LINDF_STAT_STUCK_BIT   1
`define LINDF_STAT_RXD_BIT     2

// ----------------------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------------------
`define LINDF_RESET_BYTE       8'h00
`define LINDF_RXTO_W           17
`define LINDF_CLR_W            16
`define LINDF_ACT_W            8
`define LINDF_FLT_W            4

`endif

//--- lindf_sync.v
`timescale 1ns/1ps
module lindf_sync #(
  parameter WIDTH = 3
) (
  input wire hclk,                // Bus clock
  input wire hresetn,             // Asynchronous reset, active low
  input wire [WIDTH-1:0] async_in, // Signals from outside the clock domain
  output wire [WIDTH-1:0] sync_out // Signals after two flip-flops
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= {WIDTH{1'b1}};
      sync_reg <= {WIDTH{1'b1}};
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule
